// ### core/rxsd_defines.svh
// Offsets, field positions, reset values and limits of the delay register bank
`ifndef RXSD_DEFINES_SVH
`define RXSD_DEFINES_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define RXSD_OFS_CONTROLLER_CONFIG 5'h10
`define RXSD_OFS_SAMPLE_DELAY_LOW 5'h11
`define RXSD_OFS_SAMPLE_DELAY_HIGH 5'h12
`define RXSD_OFS_STROBE_LOW_WINDOW 5'h13
`define RXSD_OFS_PHASE_STROBE_HIGH 5'h14
`define RXSD_OFS_SYNC_GAIN_PHASE_THR 5'h15
`define RXSD_OFS_SYNC_OUTPUT_DELAY 5'h16
`define RXSD_OFS_SYNC_SH_DELAY_LOW 5'h17
`define RXSD_OFS_SYNC_SH_DELAY_HIGH 5'h18
`define RXSD_OFS_FIRST 5'h10
`define RXSD_OFS_LAST 5'h18
`define RXSD_NUM_REGS 9

// ****************************************************
// Reset values
// ****************************************************
`define RXSD_RST_CONTROLLER_CONFIG 8'h42
`define RXSD_RST_SAMPLE_DELAY_LOW 8'hdd
`define RXSD_RST_SAMPLE_DELAY_HIGH 8'h29
`define RXSD_RST_STROBE_LOW_WINDOW 8'h71
`define RXSD_RST_PHASE_STROBE_HIGH 8'h0a
`define RXSD_RST_SYNC_GAIN_PHASE_THR 8'h00
`define RXSD_RST_SYNC_OUTPUT_DELAY 8'h00
`define RXSD_RST_SYNC_SH_DELAY_LOW 8'h00
`define RXSD_RST_SYNC_SH_DELAY_HIGH 8'h00

// ****************************************************
// Field positions
// ****************************************************
`define RXSD_BIT_RECEIVER_ENABLE 0
`define RXSD_BIT_SYNC_ENABLE 4
`define RXSD_BIT_SPI_READ 7
`define RXSD_DELAY_MAX 10'h14c
`define RXSD_SPI_BITS 4'h7

`endif

// ### core/rxsd_pkg.sv
// Types shared by the delay register bank and its serial port
package rxsd_pkg;

    typedef logic [7:0] rxsd_byte_t;
    typedef logic [4:0] rxsd_addr_t;
    typedef logic [9:0] rxsd_delay_t;

    typedef enum logic [2:0] {
        SPI_IDLE,
        SPI_INSTR,
        SPI_WDATA,
        SPI_RLOAD,
        SPI_RDATA,
        SPI_DONE
    } rxsd_spi_state_t;

endpackage : rxsd_pkg

// ### core/rxsd_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
module rxsd_pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // A bit only changes once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : pin_q[i];
        end
    end

    // Stage one is read by stage two only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            pin_q <= INIT;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            pin_q <= next_q;
        end
    end

endmodule : rxsd_pin_sync

// ### core/rxsd_spi_slave.sv
// Serial configuration port: 8-bit instruction then 8-bit data, mode 0
`include "rxsd_defines.svh"

module rxsd_spi_slave (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire rxsd_pkg::rxsd_byte_t rdata,
    output rxsd_pkg::rxsd_addr_t addr,
    output logic wr_en,
    output rxsd_pkg::rxsd_byte_t wdata,
    output logic sdo,
    output logic sdo_oe
);
    import rxsd_pkg::*;

    rxsd_spi_state_t st;
    rxsd_spi_state_t next_st;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    rxsd_byte_t shin;
    rxsd_byte_t next_shin;
    rxsd_byte_t shout;
    rxsd_byte_t next_shout;
    rxsd_addr_t next_addr;
    rxsd_byte_t next_wdata;
    logic next_wr_en;
    logic next_sdo;
    logic next_sdo_oe;
    logic sclk_d;
    logic rise;
    logic fall;

    assign rise = sclk & ~sclk_d;
    assign fall = ~sclk & sclk_d;

    // Frame sequencer; chip select high aborts any frame at once
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_shin = shin;
        next_shout = shout;
        next_addr = addr;
        next_wdata = wdata;
        next_wr_en = 1'b0;
        next_sdo = sdo;
        next_sdo_oe = sdo_oe;
        if (cs_n) begin
            next_st = SPI_IDLE;
            next_cnt = 4'h0;
            next_sdo_oe = 1'b0;
        end else begin
            case (st)
                SPI_IDLE: begin
                    next_st = SPI_INSTR;
                    next_cnt = 4'h0;
                end
                SPI_INSTR: begin
                    if (rise) begin
                        next_shin = {shin[6:0], sdi};
                        next_cnt = cnt + 4'h1;
                        if (cnt == `RXSD_SPI_BITS) begin
                            next_cnt = 4'h0;
                            next_addr = {shin[3:0], sdi};
                            next_st = shin[`RXSD_BIT_SPI_READ - 1] ?
                                      SPI_RLOAD : SPI_WDATA;
                        end
                    end
                end
                SPI_WDATA: begin
                    if (rise) begin
                        next_shin = {shin[6:0], sdi};
                        next_cnt = cnt + 4'h1;
                        if (cnt == `RXSD_SPI_BITS) begin
                            next_wdata = {shin[6:0], sdi};
                            next_wr_en = 1'b1;
                            next_st = SPI_DONE;
                        end
                    end
                end
                SPI_RLOAD: begin
                    // Address is registered, so read data is valid now
                    next_shout = rdata;
                    next_st = SPI_RDATA;
                end
                SPI_RDATA: begin
                    if (fall) begin
                        next_sdo = shout[7];
                        next_sdo_oe = 1'b1;
                        next_shout = {shout[6:0], 1'b0};
                        next_cnt = cnt + 4'h1;
                        if (cnt == `RXSD_SPI_BITS) begin
                            next_st = SPI_DONE;
                        end
                    end
                end
                SPI_DONE: begin
                    next_st = SPI_DONE;
                end
                default: begin
                    next_st = SPI_IDLE;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= SPI_IDLE;
            cnt <= 4'h0;
            shin <= 8'h00;
            shout <= 8'h00;
            addr <= 5'h00;
            wdata <= 8'h00;
            wr_en <= 1'b0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            sclk_d <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            shin <= next_shin;
            shout <= next_shout;
            addr <= next_addr;
            wdata <= next_wdata;
            wr_en <= next_wr_en;
            sdo <= next_sdo;
            sdo_oe <= next_sdo_oe;
            sclk_d <= sclk;
        end
    end

endmodule : rxsd_spi_slave

// ### core/rxsd_regs.sv
// Receiver and sync controller delay configuration register bank
//
// How it works
// - Enabled: sample delay is search start, max 332
// - Disabled: sample delay drives delay line directly
// - Enabled: strobe delay is search start, max 332
// - Disabled: strobe delay drives delay line directly
// - Window field sets early/late strobe separation
// - Phase field rotates divider, sync disabled only
// - Two-bit field sets sync tracking gain
// - Field reads back current sync output phase
// - Threshold sets allowed sample/strobe delay difference
// - Sync output delay: setting, or status when enabled
// - Setup/hold delay: setting, or status when enabled
// - Config bit 0 enables receiver controller
// - Config bit 4 enables sync controller
`include "rxsd_defines.svh"

module rxsd_regs (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire rxsd_pkg::rxsd_delay_t ctrl_sample_delay,
    input wire rxsd_pkg::rxsd_delay_t ctrl_strobe_delay,
    input wire logic [1:0] sync_output_phase_sel,
    input wire logic [6:0] ctrl_sync_output_delay,
    input wire logic [8:0] ctrl_sync_setup_hold_delay,
    output logic receiver_ctrl_enable,
    output logic sync_ctrl_enable,
    output rxsd_pkg::rxsd_delay_t sample_delay_start,
    output rxsd_pkg::rxsd_delay_t sample_delay_line,
    output rxsd_pkg::rxsd_delay_t strobe_delay_start,
    output rxsd_pkg::rxsd_delay_t strobe_delay_line,
    output logic [3:0] pre_post_window_width,
    output logic [1:0] divider_phase_rotation,
    output logic [1:0] sync_tracking_gain,
    output logic [3:0] lock_delta_threshold,
    output logic [6:0] sync_output_delay_line,
    output logic [8:0] sync_setup_hold_delay_line
);
    import rxsd_pkg::*;

    // ****************************************************
    // Helper functions
    // ****************************************************

    // True for an offset inside the bank
    function automatic logic reg_hit(input rxsd_addr_t a);
        reg_hit = (a >= `RXSD_OFS_FIRST) && (a <= `RXSD_OFS_LAST);
    endfunction : reg_hit

    // Bank slot of an offset
    function automatic logic [3:0] reg_slot(input rxsd_addr_t a);
        rxsd_addr_t d;
        d = a - `RXSD_OFS_FIRST;
        reg_slot = d[3:0];
    endfunction : reg_slot

    // Delay lines stop at 332; larger codes saturate there
    function automatic rxsd_delay_t clamp_delay(input rxsd_delay_t v);
        clamp_delay = (v > `RXSD_DELAY_MAX) ? `RXSD_DELAY_MAX : v;
    endfunction : clamp_delay

    // Reset value of each slot
    function automatic rxsd_byte_t reset_value(input int i);
        case (i)
            0: reset_value = `RXSD_RST_CONTROLLER_CONFIG;
            1: reset_value = `RXSD_RST_SAMPLE_DELAY_LOW;
            2: reset_value = `RXSD_RST_SAMPLE_DELAY_HIGH;
            3: reset_value = `RXSD_RST_STROBE_LOW_WINDOW;
            4: reset_value = `RXSD_RST_PHASE_STROBE_HIGH;
            5: reset_value = `RXSD_RST_SYNC_GAIN_PHASE_THR;
            6: reset_value = `RXSD_RST_SYNC_OUTPUT_DELAY;
            7: reset_value = `RXSD_RST_SYNC_SH_DELAY_LOW;
            8: reset_value = `RXSD_RST_SYNC_SH_DELAY_HIGH;
            default: reset_value = 8'h00;
        endcase
    endfunction : reset_value

    // ****************************************************
    // Serial port
    // ****************************************************

    logic [2:0] pins_q;
    rxsd_addr_t bus_addr;
    logic bus_wr;
    rxsd_byte_t bus_wdata;
    rxsd_byte_t bus_rdata;
    logic next_sdo;
    logic next_sdo_oe;

    // Idle levels: clock low, select high, data low
    rxsd_pin_sync #(
        .W(3),
        .INIT(3'h2)
    ) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pin_in({spi_sclk, spi_cs_n, spi_sdi}),
        .pin_q(pins_q)
    );

    rxsd_spi_slave u_spi (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sclk(pins_q[2]),
        .cs_n(pins_q[1]),
        .sdi(pins_q[0]),
        .rdata(bus_rdata),
        .addr(bus_addr),
        .wr_en(bus_wr),
        .wdata(bus_wdata),
        .sdo(next_sdo),
        .sdo_oe(next_sdo_oe)
    );

    // ****************************************************
    // Register storage
    // ****************************************************

    rxsd_byte_t bank [`RXSD_NUM_REGS];
    rxsd_byte_t next_bank [`RXSD_NUM_REGS];

    // Writes to offsets outside the bank are dropped
    always_comb begin
        for (int i = 0; i < `RXSD_NUM_REGS; i++) begin
            next_bank[i] = bank[i];
        end
        if (bus_wr && reg_hit(bus_addr)) begin
            next_bank[reg_slot(bus_addr)] = bus_wdata;
        end
    end

    // Bank registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `RXSD_NUM_REGS; i++) begin
                bank[i] <= reset_value(i);
            end
        end else begin
            for (int i = 0; i < `RXSD_NUM_REGS; i++) begin
                bank[i] <= next_bank[i];
            end
        end
    end

    // ****************************************************
    // Field extraction
    // ****************************************************

    logic rcv_en;
    logic syn_en;
    rxsd_delay_t smp_field;
    rxsd_delay_t stb_field;
    logic [8:0] sh_field;

    assign rcv_en = bank[0][`RXSD_BIT_RECEIVER_ENABLE];
    assign syn_en = bank[0][`RXSD_BIT_SYNC_ENABLE];
    assign smp_field = {bank[2], bank[1][7:6]};
    assign stb_field = {bank[4][5:0], bank[3][7:4]};
    assign sh_field = {bank[8], bank[7][7]};

    // ****************************************************
    // Read path
    // ****************************************************

    // Sync delay status overlays replace settings while the sync loop runs; the phase field is overlaid always
    always_comb begin
        bus_rdata = 8'h00;
        if (reg_hit(bus_addr)) begin
            bus_rdata = bank[reg_slot(bus_addr)];
        end
        case (bus_addr)
            `RXSD_OFS_SYNC_GAIN_PHASE_THR: begin
                bus_rdata[5:4] = sync_output_phase_sel;
            end
            `RXSD_OFS_SYNC_OUTPUT_DELAY: begin
                bus_rdata = syn_en ? {1'b0, ctrl_sync_output_delay}
                                   : {1'b0, bank[6][6:0]};
            end
            `RXSD_OFS_SYNC_SH_DELAY_LOW: begin
                if (syn_en) begin
                    bus_rdata[7] = ctrl_sync_setup_hold_delay[0];
                end
            end
            `RXSD_OFS_SYNC_SH_DELAY_HIGH: begin
                if (syn_en) begin
                    bus_rdata = ctrl_sync_setup_hold_delay[8:1];
                end
            end
            default: begin
                bus_rdata = bus_rdata;
            end
        endcase
    end

    // ****************************************************
    // Outputs to the controllers and delay lines
    // ****************************************************

    rxsd_delay_t next_smp_start;
    rxsd_delay_t next_smp_line;
    rxsd_delay_t next_stb_start;
    rxsd_delay_t next_stb_line;
    logic [1:0] next_phase;
    logic [6:0] next_so_line;
    logic [8:0] next_sh_line;

    // Enabled: field seeds the search and the controller owns the line.
    // Disabled: field goes straight to the line, no search.
    always_comb begin
        next_smp_start = clamp_delay(smp_field);
        next_stb_start = clamp_delay(stb_field);
        next_smp_line = rcv_en ? clamp_delay(ctrl_sample_delay)
                               : clamp_delay(smp_field);
        next_stb_line = rcv_en ? clamp_delay(ctrl_strobe_delay)
                               : clamp_delay(stb_field);
        // Rotation is meaningless once the sync loop picks phase
        next_phase = syn_en ? 2'h0 : bank[4][7:6];
        next_so_line = syn_en ? ctrl_sync_output_delay
                              : bank[6][6:0];
        next_sh_line = syn_en ? ctrl_sync_setup_hold_delay
                              : sh_field;
    end

    // Every top output is a flop; values follow the bank one cycle late
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
            receiver_ctrl_enable <= 1'b0;
            sync_ctrl_enable <= 1'b0;
            sample_delay_start <= 10'h000;
            sample_delay_line <= 10'h000;
            strobe_delay_start <= 10'h000;
            strobe_delay_line <= 10'h000;
            pre_post_window_width <= 4'h0;
            divider_phase_rotation <= 2'h0;
            sync_tracking_gain <= 2'b00;
            lock_delta_threshold <= 4'h0;
            sync_output_delay_line <= 7'h00;
            sync_setup_hold_delay_line <= 9'h000;
        end else begin
            spi_sdo <= next_sdo;
            spi_sdo_oe <= next_sdo_oe;
            receiver_ctrl_enable <= rcv_en;
            sync_ctrl_enable <= syn_en;
            sample_delay_start <= next_smp_start;
            sample_delay_line <= next_smp_line;
            strobe_delay_start <= next_stb_start;
            strobe_delay_line <= next_stb_line;
            pre_post_window_width <= bank[3][3:0];
            divider_phase_rotation <= next_phase;
            sync_tracking_gain <= bank[5][7:6];
            lock_delta_threshold <= bank[5][3:0];
            sync_output_delay_line <= next_so_line;
            sync_setup_hold_delay_line <= next_sh_line;
        end
    end

endmodule : rxsd_regs

// ### tb/rxsd_regs_asserts.sv
// Port-level checks for the delay register bank
module rxsd_regs_asserts (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic spi_cs_n,
    input wire rxsd_pkg::rxsd_delay_t ctrl_sample_delay,
    input wire rxsd_pkg::rxsd_delay_t ctrl_strobe_delay,
    input wire logic [6:0] ctrl_sync_output_delay,
    input wire logic [8:0] ctrl_sync_setup_hold_delay,
    input wire logic receiver_ctrl_enable,
    input wire logic sync_ctrl_enable,
    input wire rxsd_pkg::rxsd_delay_t sample_delay_start,
    input wire rxsd_pkg::rxsd_delay_t sample_delay_line,
    input wire rxsd_pkg::rxsd_delay_t strobe_delay_start,
    input wire rxsd_pkg::rxsd_delay_t strobe_delay_line,
    input wire logic [3:0] pre_post_window_width,
    input wire logic [1:0] divider_phase_rotation,
    input wire logic [1:0] sync_tracking_gain,
    input wire logic [3:0] lock_delta_threshold,
    input wire logic [6:0] sync_output_delay_line,
    input wire logic [8:0] sync_setup_hold_delay_line
);
    import rxsd_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    logic [3:0] idle_cnt;
    logic [3:0] next_idle_cnt;

    // Saturates at the delay line limit, as the outputs must
    function automatic rxsd_delay_t limit_delay(input rxsd_delay_t v);
        return (v > 10'h14c) ? 10'h14c : v;
    endfunction : limit_delay

    // Cycles with chip select high; no write can land once it saturates
    always_comb begin
        next_idle_cnt = idle_cnt;
        if (!spi_cs_n) next_idle_cnt = 4'h0;
        else if (idle_cnt != 4'hf) next_idle_cnt = idle_cnt + 4'h1;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) idle_cnt <= 4'h0;
        else idle_cnt <= next_idle_cnt;
    end

    // ****************************************************
    // Properties
    // ****************************************************
    a_sample_cap:
        assert property (sample_delay_start <= 10'h14c)
        else $error("sample start above limit");
    a_strobe_cap:
        assert property (strobe_delay_start <= 10'h14c)
        else $error("strobe start above limit");
    a_sample_track:
        assert property (receiver_ctrl_enable [*3] |->
            sample_delay_line == limit_delay($past(ctrl_sample_delay)))
        else $error("sample line ignores controller");
    a_strobe_track:
        assert property (receiver_ctrl_enable [*3] |->
            strobe_delay_line == limit_delay($past(ctrl_strobe_delay)))
        else $error("strobe line ignores controller");
    a_sample_direct:
        assert property (!receiver_ctrl_enable [*3] |->
            sample_delay_line == sample_delay_start)
        else $error("sample line not set directly");
    a_strobe_direct:
        assert property (!receiver_ctrl_enable [*3] |->
            strobe_delay_line == strobe_delay_start)
        else $error("strobe line not set directly");
    a_phase_forced:
        assert property (sync_ctrl_enable [*2] |->
            divider_phase_rotation == 2'h0)
        else $error("phase rotation while sync enabled");
    a_sync_out_status:
        assert property (sync_ctrl_enable [*3] |->
            sync_output_delay_line == $past(ctrl_sync_output_delay))
        else $error("sync output delay not tracking");
    a_sync_sh_status:
        assert property (sync_ctrl_enable [*3] |->
            sync_setup_hold_delay_line == $past(ctrl_sync_setup_hold_delay))
        else $error("setup hold delay not tracking");
    a_idle_hold:
        assert property (idle_cnt == 4'hf |-> $stable({sample_delay_start,
            strobe_delay_start, pre_post_window_width, sync_tracking_gain,
            lock_delta_threshold, divider_phase_rotation,
            receiver_ctrl_enable, sync_ctrl_enable}))
        else $error("setting moved without a frame");
    a_sync_hold:
        assert property (idle_cnt == 4'hf && !sync_ctrl_enable |->
            $stable({sync_output_delay_line, sync_setup_hold_delay_line}))
        else $error("sync setting moved without a frame");

    c_rx_on: cover property (receiver_ctrl_enable [*3]);
    c_sync_on: cover property (sync_ctrl_enable [*3]);
    c_capped: cover property (sample_delay_line == 10'h14c);
endmodule : rxsd_regs_asserts

bind rxsd_regs rxsd_regs_asserts rxsd_regs_asserts_i (.ref_clk, .arst_n,
    .spi_cs_n, .ctrl_sample_delay, .ctrl_strobe_delay,
    .ctrl_sync_output_delay, .ctrl_sync_setup_hold_delay,
    .receiver_ctrl_enable, .sync_ctrl_enable, .sample_delay_start,
    .sample_delay_line, .strobe_delay_start, .strobe_delay_line,
    .pre_post_window_width, .divider_phase_rotation, .sync_tracking_gain,
    .lock_delta_threshold, .sync_output_delay_line,
    .sync_setup_hold_delay_line);

// ### tb/rxsd_regs_tb.sv
// Self-checking bench for the delay register bank over its serial port
module rxsd_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rxsd_pkg::*;

    logic ref_clk, arst_n, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
    rxsd_delay_t ctrl_sample_delay, ctrl_strobe_delay;
    rxsd_delay_t sample_delay_start, sample_delay_line;
    rxsd_delay_t strobe_delay_start, strobe_delay_line;
    logic [1:0] sync_output_phase_sel, divider_phase_rotation;
    logic [1:0] sync_tracking_gain;
    logic [6:0] ctrl_sync_output_delay, sync_output_delay_line;
    logic [8:0] ctrl_sync_setup_hold_delay, sync_setup_hold_delay_line;
    logic [3:0] pre_post_window_width, lock_delta_threshold;
    logic receiver_ctrl_enable, sync_ctrl_enable;
    int n_fail, check_count;
    rxsd_byte_t rst_tab [9] = '{8'h42, 8'hdd, 8'h29, 8'h71, 8'h0a,
        8'h00, 8'h00, 8'h00, 8'h00};

    rxsd_regs rxsd_regs_i (.ref_clk, .arst_n, .spi_sclk, .spi_cs_n,
        .spi_sdi, .spi_sdo, .spi_sdo_oe, .ctrl_sample_delay,
        .ctrl_strobe_delay, .sync_output_phase_sel, .ctrl_sync_output_delay,
        .ctrl_sync_setup_hold_delay, .receiver_ctrl_enable,
        .sync_ctrl_enable, .sample_delay_start, .sample_delay_line,
        .strobe_delay_start, .strobe_delay_line, .pre_post_window_width,
        .divider_phase_rotation, .sync_tracking_gain, .lock_delta_threshold,
        .sync_output_delay_line, .sync_setup_hold_delay_line);
    // 25 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic ticks(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : ticks

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk_rd(input rxsd_byte_t got, input rxsd_byte_t exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk_rd

    task automatic chk_out(input rxsd_delay_t got, input rxsd_delay_t exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t output %h expected %h", $time, got, exp);
        end
    endtask : chk_out

    // Phases of 8 cycles clear the 4-cycle pin filter; short nb aborts
    task automatic spi(input rxsd_byte_t ins, input rxsd_byte_t dat,
        input int nb, output rxsd_byte_t rd);
        logic [15:0] word;
        word = {ins, dat};
        rd = 8'h00;
        spi_cs_n = 1'b0;
        ticks(8);
        for (int i = 0; i < nb; i++) begin
            spi_sdi = word[15 - i];
            ticks(8);
            if (i >= 8 && ins[7]) begin
                rd = {rd[6:0], spi_sdo};
                chk_out(10'(spi_sdo_oe), 10'h1);
            end
            spi_sclk = 1'b1;
            ticks(8);
            spi_sclk = 1'b0;
        end
        ticks(8);
        spi_cs_n = 1'b1;
        ticks(16);
    endtask : spi

    task automatic wr(input rxsd_addr_t a, input rxsd_byte_t d);
        rxsd_byte_t unused;
        spi({3'h0, a}, d, 16, unused);
    endtask : wr

    task automatic rd(input rxsd_addr_t a, input rxsd_byte_t exp);
        rxsd_byte_t got;
        spi({3'h4, a}, 8'h00, 16, got);
        chk_rd(got, exp);
        chk_out(10'(spi_sdo_oe), 10'h0);
    endtask : rd

    // Cuts a hang short; a full run is roughly 11k cycles
    initial begin
        #2000000;
        n_fail++;
        finish_test();
    end

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        rxsd_byte_t dummy;
        {arst_n, spi_sclk, spi_sdi} = 3'h0;
        spi_cs_n = 1'b1;
        {ctrl_sample_delay, ctrl_strobe_delay} = 20'h0;
        {ctrl_sync_output_delay, ctrl_sync_setup_hold_delay} = 16'h0;
        sync_output_phase_sel = 2'h0;
        n_fail = 0;
        check_count = 0;
        ticks(3);
        arst_n = 1'b1;
        ticks(6);
        foreach (rst_tab[i]) rd(5'(5'h10 + i), rst_tab[i]);
        chk_out(sample_delay_line, 10'h0a7);
        chk_out(strobe_delay_line, 10'h0a7);
        chk_out(10'(pre_post_window_width), 10'h1);
        // Unmapped offset reads zero
        wr(5'h05, 8'h5a);
        rd(5'h05, 8'h00);
        // Boundary either side of the limit
        wr(5'h12, 8'h53);
        wr(5'h11, 8'h40);
        chk_out(sample_delay_start, 10'h14c);
        chk_out(sample_delay_line, 10'h14c);
        rd(5'h11, 8'h40);
        wr(5'h12, 8'h52);
        wr(5'h11, 8'hc0);
        chk_out(sample_delay_start, 10'h14b);
        chk_out(sample_delay_line, 10'h14b);
        wr(5'h14, 8'h3f);
        chk_out(strobe_delay_start, 10'h14c);
        wr(5'h13, 8'h52);
        wr(5'h14, 8'hc8);
        chk_out(strobe_delay_start, 10'h085);
        chk_out(strobe_delay_line, 10'h085);
        chk_out(10'(pre_post_window_width), 10'h2);
        chk_out(10'(divider_phase_rotation), 10'h3);
        // Receiver controller owns both lines
        ctrl_sample_delay = 10'h3ff;
        ctrl_strobe_delay = 10'h0a5;
        wr(5'h10, 8'h43);
        chk_out(10'(receiver_ctrl_enable), 10'h1);
        chk_out(sample_delay_line, 10'h14c);
        chk_out(strobe_delay_line, 10'h0a5);
        chk_out(sample_delay_start, 10'h14b);
        ctrl_sample_delay = 10'h001;
        ticks(3);
        chk_out(sample_delay_line, 10'h001);
        wr(5'h10, 8'h42);
        chk_out(sample_delay_line, 10'h14b);
        chk_out(strobe_delay_line, 10'h085);
        // Gain, threshold, every phase readback
        wr(5'h15, 8'h7f);
        chk_out(10'(sync_tracking_gain), 10'h1);
        chk_out(10'(lock_delta_threshold), 10'hf);
        for (int p = 0; p < 4; p++) begin
            sync_output_phase_sel = 2'(p);
            rd(5'h15, {2'h1, 2'(p), 4'hf});
        end
        // Sync delays as settings, then an abort
        wr(5'h16, 8'hff);
        wr(5'h17, 8'h80);
        wr(5'h18, 8'ha5);
        chk_out(10'(sync_output_delay_line), 10'h07f);
        chk_out(10'(sync_setup_hold_delay_line), 10'h14b);
        spi(8'h16, 8'h11, 12, dummy);
        rd(5'h16, 8'h7f);
        // Sync controller on: delays become status
        ctrl_sync_output_delay = 7'h35;
        ctrl_sync_setup_hold_delay = 9'h1c2;
        wr(5'h10, 8'h52);
        chk_out(10'(sync_ctrl_enable), 10'h1);
        chk_out(10'(divider_phase_rotation), 10'h0);
        chk_out(10'(sync_output_delay_line), 10'h035);
        chk_out(10'(sync_setup_hold_delay_line), 10'h1c2);
        rd(5'h16, 8'h35);
        rd(5'h17, 8'h00);
        rd(5'h18, 8'he1);
        wr(5'h10, 8'h42);
        chk_out(10'(sync_output_delay_line), 10'h07f);
        chk_out(10'(divider_phase_rotation), 10'h3);
        rd(5'h10, 8'h42);
        // Second reset restores defaults
        arst_n = 1'b0;
        ticks(3);
        arst_n = 1'b1;
        ticks(6);
        rd(5'h16, 8'h00);
        chk_out(sample_delay_start, 10'h0a7);
        finish_test();
    end
endmodule : rxsd_regs_tb
